/* core/flow_pkg.sv */
// Purpose: shared constants and types for the port flow control register block
// Assumes: 32-bit axi4-lite data, 12-bit byte address space
// Notes:   field positions follow the register layout; codes below are local
package flow_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register byte address and field positions
	localparam logic [ADDR_W-1:0] FLOW_CTRL_OFFSET = 12'h1A0;
	localparam int unsigned       BIT_BACKPRESSURE = 6;
	localparam int unsigned       BIT_CUR_DUPLEX   = 5;
	localparam int unsigned       BIT_CUR_PAUSE_RX = 4;
	localparam int unsigned       BIT_CUR_PAUSE_TX = 3;
	localparam int unsigned       BIT_PAUSE_RX     = 2;
	localparam int unsigned       BIT_PAUSE_TX     = 1;
	localparam int unsigned       BIT_MANUAL       = 0;

	// values held before the straps are captured
	localparam logic FIELD_RESET = 1'b0;

	// cycles the strap synchronisers get to settle after reset release
	localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// interface mode of the port; codes are local to this block
	typedef enum logic [1:0] {
		MODE_INTERNAL_PHY = 2'h0,
		MODE_MII_PHY      = 2'h1,
		MODE_RMII_PHY     = 2'h2,
		MODE_MII_MAC      = 2'h3
	} port_mode_e;

	// start-up sequence, gray coded
	typedef enum logic [1:0] {
		INIT_SETTLE  = 2'h0,
		INIT_CAPTURE = 2'h1,
		INIT_RUN     = 2'h3
	} init_state_e;
endpackage

/* core/reg_access_if.sv */
// Purpose: simple register access strobes between bus front end and register bank
// Assumes: one clock domain, strobes are single-cycle pulses
// Notes:   ok and read data are answered combinationally in the strobe cycle
`timescale 1ns/10ps
interface reg_access_if;
	import flow_pkg::*;
	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0]        wr_strb;
	logic              wr_ok;
	logic              rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic              rd_ok;

	modport front (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
	modport bank  (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

/* core/strap_sync.sv */
// Purpose: two-flop synchroniser for a group of strap pins
// Assumes: pins are quasi-static levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module strap_sync #(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] level_q;

	// one pair of flops per pin
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				meta_q[i]  <= 1'b0;
				level_q[i] <= 1'b0;
			end else begin
				meta_q[i]  <= pin[i];
				level_q[i] <= meta_q[i];
			end
		end
	end

	assign level = level_q;
endmodule // strap_sync

/* core/axil_front.sv */
// Purpose: axi4-lite slave front end turning bus beats into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   write address and data are taken in either order
`timescale 1ns/10ps
module axil_front
	import flow_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [DATA_W-1:0] rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	reg_access_if.front            regs
);
	logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0]        w_strb_q;
	logic              awready_q, wready_q, bvalid_q, bvalid_d, arready_q, rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, rresp_q;
	logic [DATA_W-1:0] rdata_q;
	logic              aw_take, w_take, do_wr, ar_take;

	// handshakes and next state; ready drops while a beat is held so it cannot be overrun
	assign aw_take   = awvalid & awready_q;
	assign w_take    = wvalid & wready_q;
	assign do_wr     = aw_held_q & w_held_q & ~bvalid_q;
	assign ar_take   = arvalid & arready_q;
	assign aw_held_d = do_wr ? 1'b0 : (aw_held_q | aw_take);
	assign w_held_d  = do_wr ? 1'b0 : (w_held_q | w_take);
	assign bvalid_d  = do_wr | (bvalid_q & ~bready);
	assign rvalid_d  = ar_take | (rvalid_q & ~rready);

	// strobes toward the register bank
	assign regs.wr_en   = do_wr;
	assign regs.wr_addr = aw_addr_q;
	assign regs.wr_data = w_data_q;
	assign regs.wr_strb = w_strb_q;
	assign regs.rd_en   = ar_take;
	assign regs.rd_addr = araddr;

	// write path
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awready_q <= ~aw_held_d & ~bvalid_d;
			wready_q  <= ~w_held_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (do_wr) begin
				bresp_q <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// payload capture needs no reset, it is only read behind the held flags
	always_ff @(posedge ref_clk) begin
		if (aw_take) begin
			aw_addr_q <= awaddr;
		end
		if (w_take) begin
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
	end

	// read path
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= '0;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_take) begin
				rdata_q <= regs.rd_ok ? regs.rd_data : '0;
				rresp_q <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	assign awready = awready_q;
	assign wready  = wready_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = arready_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
endmodule // axil_front

/* core/port_flow_control_select.sv */
// Purpose: flow control select and status register for switch port one
// Assumes: loader and negotiation inputs share ref_clk; strap pins are asynchronous
// Notes:   register stands alone on its own axi4-lite slave
// Function
// - bit 6 enables half-duplex forced-collision backpressure on the port.
// - bit 5 reads duplex in force, 0 full, 1 half.
// - bit 4 reads whether pause reception is active now.
// - bit 3 reads whether pause transmission is active now.
// - bit 2 enables pause frame reception when manual or negotiation off.
// - bit 1 enables pause frame generation when manual or negotiation off.
// - bit 0 clear uses negotiated pause if negotiating, else bits 1 and 2.
// - manual select applies bits 1 and 2 whenever the port is full duplex.
// - fixed mii/rmii modes hold manual select at one, read-only.
// - fixed modes reset manual to one, loader skips it; else strap default.
// - defaults come from latched straps; loader rewrites update the register.
// - writes here never touch the phy advertisement pause capability.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module port_flow_control_select
	import flow_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              reset,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic      [1:0]        s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic      [DATA_W-1:0] s_axi_rdata,
	output logic      [1:0]        s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// configuration strap pins
	input  wire logic              backpressure_default_strap,
	input  wire logic              pause_default_strap,
	input  wire logic              manual_select_default_strap,
	// eeprom loader strap rewrite
	input  wire logic              loader_strap_write,
	input  wire logic              loader_backpressure,
	input  wire logic              loader_pause,
	input  wire logic              loader_manual,
	// port mode and negotiation result
	input  wire port_mode_e        port_if_mode,
	input  wire logic              an_enable,
	input  wire logic              an_pause_rx,
	input  wire logic              an_pause_tx,
	input  wire logic              link_half_duplex,
	// controls toward the mac
	output logic                   backpressure_active,
	output logic                   pause_rx_active,
	output logic                   pause_tx_active,
	output logic                   config_ready
);
	reg_access_if regs ();

	logic [2:0]  strap_level;
	logic        strap_bp, strap_pause, strap_manual;
	init_state_e state_q, state_d;
	logic [2:0]  settle_q, settle_d;
	logic        capture, running;

	logic        backpressure_enable_q, backpressure_enable_d;
	logic        pause_rx_enable_q, pause_rx_enable_d;
	logic        pause_tx_enable_q, pause_tx_enable_d;
	logic        manual_pause_select_q, manual_pause_select_d;

	logic        current_duplex_flag_q;
	logic        current_pause_rx_active_q, current_pause_tx_active_q;
	logic        backpressure_active_q;
	logic        config_ready_q;

	logic        fixed_mode, manual_eff, use_bits, full_duplex;
	logic        pause_rx_next, pause_tx_next, bp_next;
	logic        wr_hit, rd_hit, sw_wr, load_now;
	logic        load_bp, load_pause, load_manual;
	logic [DATA_W-1:0] readback;

	// strap pins are asynchronous, so each goes through two flops first
	strap_sync #(
		.WIDTH (3)
	) u_strap_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     ({manual_select_default_strap, pause_default_strap, backpressure_default_strap}),
		.level   (strap_level)
	);

	assign strap_bp     = strap_level[0];
	assign strap_pause  = strap_level[1];
	assign strap_manual = strap_level[2];

	// bus front end
	axil_front u_axil_front (
		.ref_clk (ref_clk),
		.reset   (reset),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.regs    (regs.front)
	);

	// start-up sequence: let the synchronisers settle, capture the straps once, then run
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		unique case (state_q)
			INIT_SETTLE: begin
				settle_d = settle_q + 3'h1;
				if (settle_q == STRAP_SETTLE_CYCLES - 3'h1) begin
					state_d = INIT_CAPTURE;
				end
			end
			INIT_CAPTURE: begin
				state_d = INIT_RUN;
			end
			INIT_RUN: begin
				state_d = INIT_RUN;
			end
			default: begin
				state_d  = INIT_SETTLE;
				settle_d = 3'h0;
			end
		endcase
	end

	// straps are caught after release, never inside the reset branch
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q  <= INIT_SETTLE;
			settle_q <= 3'h0;
		end else begin
			state_q  <= state_d;
			settle_q <= settle_d;
		end
	end

	assign capture = (state_q == INIT_CAPTURE);
	assign running = (state_q == INIT_RUN);

	// address decode; one word, anything else answers slave error
	assign wr_hit       = (regs.wr_addr == FLOW_CTRL_OFFSET);
	assign rd_hit       = (regs.rd_addr == FLOW_CTRL_OFFSET);
	assign regs.wr_ok   = wr_hit;
	assign regs.rd_ok   = rd_hit;

	// only the low byte holds fields, so only its strobe commits a write
	assign sw_wr = regs.wr_en & wr_hit & regs.wr_strb[0] & running;

	// fixed interface modes have no negotiation and force manual select
	assign fixed_mode = (port_if_mode != MODE_INTERNAL_PHY);

	// strap load source: reset capture first, then loader rewrites
	assign load_now    = capture | (running & loader_strap_write);
	assign load_bp     = capture ? strap_bp : loader_backpressure;
	assign load_pause  = capture ? strap_pause : loader_pause;
	assign load_manual = capture ? strap_manual : loader_manual;

	// backpressure enable; a loader rewrite in the same cycle beats software
	assign backpressure_enable_d = load_now ? load_bp :
	                               sw_wr ? regs.wr_data[BIT_BACKPRESSURE] :
	                               backpressure_enable_q;

	// pause enables share one full-duplex pause strap
	assign pause_rx_enable_d = load_now ? load_pause :
	                           sw_wr ? regs.wr_data[BIT_PAUSE_RX] :
	                           pause_rx_enable_q;
	assign pause_tx_enable_d = load_now ? load_pause :
	                           sw_wr ? regs.wr_data[BIT_PAUSE_TX] :
	                           pause_tx_enable_q;

	// manual select: held at one in fixed modes, where neither software nor loader reach it
	assign manual_pause_select_d = fixed_mode ? 1'b1 :
	                               load_now ? load_manual :
	                               sw_wr ? regs.wr_data[BIT_MANUAL] :
	                               manual_pause_select_q;

	// register fields; writes land here only and never reach the phy advertisement
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			backpressure_enable_q <= FIELD_RESET;
			pause_rx_enable_q     <= FIELD_RESET;
			pause_tx_enable_q     <= FIELD_RESET;
			manual_pause_select_q <= FIELD_RESET;
		end else begin
			backpressure_enable_q <= backpressure_enable_d;
			pause_rx_enable_q     <= pause_rx_enable_d;
			pause_tx_enable_q     <= pause_tx_enable_d;
			manual_pause_select_q <= manual_pause_select_d;
		end
	end

	// the forced value also covers the cycle after a mode change, before the flop follows
	assign manual_eff  = fixed_mode | manual_pause_select_q;
	assign use_bits    = manual_eff | ~an_enable;
	assign full_duplex = ~link_half_duplex;

	// pause is a full-duplex mechanism; half duplex uses backpressure instead
	assign pause_rx_next = running & full_duplex &
	                       (use_bits ? pause_rx_enable_q : an_pause_rx);
	assign pause_tx_next = running & full_duplex &
	                       (use_bits ? pause_tx_enable_q : an_pause_tx);
	assign bp_next       = running & link_half_duplex & backpressure_enable_q;

	// settings in force; registered so the mac sees glitch-free levels
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			current_duplex_flag_q     <= 1'b0;
			current_pause_rx_active_q <= 1'b0;
			current_pause_tx_active_q <= 1'b0;
			backpressure_active_q     <= 1'b0;
			config_ready_q            <= 1'b0;
		end else begin
			current_duplex_flag_q     <= link_half_duplex;
			current_pause_rx_active_q <= pause_rx_next;
			current_pause_tx_active_q <= pause_tx_next;
			backpressure_active_q     <= bp_next;
			config_ready_q            <= running;
		end
	end

	// readback word; status bits lag their inputs by one cycle
	always_comb begin
		readback                   = '0;
		readback[BIT_BACKPRESSURE] = backpressure_enable_q;
		readback[BIT_CUR_DUPLEX]   = current_duplex_flag_q;
		readback[BIT_CUR_PAUSE_RX] = current_pause_rx_active_q;
		readback[BIT_CUR_PAUSE_TX] = current_pause_tx_active_q;
		readback[BIT_PAUSE_RX]     = pause_rx_enable_q;
		readback[BIT_PAUSE_TX]     = pause_tx_enable_q;
		readback[BIT_MANUAL]       = manual_eff;
	end

	assign regs.rd_data = readback;

	// outputs straight from flops
	assign backpressure_active = backpressure_active_q;
	assign pause_rx_active     = current_pause_rx_active_q;
	assign pause_tx_active     = current_pause_tx_active_q;
	assign config_ready        = config_ready_q;
endmodule // port_flow_control_select

/* verification/port_flow_control_select_chk.sv */
// Purpose: concurrent checks on the port flow control register block
// Assumes: one clock domain, reset synchronous active high
// Notes:   watches top-level ports only, attached by bind
`timescale 1ns/10ps
module port_flow_control_select_chk
	import flow_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              reset,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire port_mode_e        port_if_mode,
	input wire logic              link_half_duplex,
	input wire logic              backpressure_active,
	input wire logic              pause_rx_active,
	input wire logic              pause_tx_active,
	input wire logic              config_ready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// write answer: one held cycle, then the response
	sequence wr_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	// fresh read data with an okay response
	sequence rd_fresh;
		$rose(s_axi_rvalid) && s_axi_rresp == RESP_OKAY;
	endsequence

	a_bp_half_only: assert property (
		backpressure_active |-> $past(link_half_duplex) && config_ready)
		else $error("backpressure active without half duplex");
	a_rx_full_only: assert property (
		pause_rx_active |-> !$past(link_half_duplex) && config_ready)
		else $error("pause receive active in half duplex");
	a_tx_full_only: assert property (
		pause_tx_active |-> !$past(link_half_duplex) && config_ready)
		else $error("pause transmit active in half duplex");
	a_rsv_read_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
		else $error("reserved bits read nonzero");
	a_fixed_manual_one: assert property (
		rd_fresh and $past(config_ready) && $past(port_if_mode) != MODE_INTERNAL_PHY |-> s_axi_rdata[0])
		else $error("manual select reads zero in fixed mode");
	a_duplex_status: assert property (
		rd_fresh and $past(config_ready, 2) |-> s_axi_rdata[5] == $past(link_half_duplex, 2))
		else $error("duplex status disagrees with link");
	a_wr_resp_time: assert property (
		wr_both_taken |=> wr_answer)
		else $error("write response not two cycles after acceptance");
	a_rd_resp_time: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after acceptance");
	// once straps are captured the block stays configured until reset
	a_ready_stays: assert property (
		config_ready |=> config_ready)
		else $error("config ready dropped");
endmodule // port_flow_control_select_chk

bind port_flow_control_select port_flow_control_select_chk i_chk (.*);

/* verification/port_flow_control_select_tb.sv */
// Purpose: self-checking bench for the port flow control register block
// Assumes: axi4-lite master tasks, registers reached at byte 0x1A0
// Notes:   inputs driven by non-blocking assignment at the rising edge
`timescale 1ns/10ps
module port_flow_control_select_tb;
	import flow_pkg::*;
	logic              ref_clk = 0;
	logic              reset = 1;
	logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic              s_axi_arvalid = 0, s_axi_rready = 0;
	logic [DATA_W-1:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              backpressure_default_strap = 1, pause_default_strap = 1, manual_select_default_strap = 0;
	logic              loader_strap_write = 0, loader_backpressure = 0, loader_pause = 0, loader_manual = 0;
	port_mode_e        port_if_mode = MODE_INTERNAL_PHY;
	logic              an_enable = 1, an_pause_rx = 0, an_pause_tx = 1, link_half_duplex = 0;
	logic              backpressure_active, pause_rx_active, pause_tx_active, config_ready;
	int                err_count = 0, check_count = 0, cycle_count = 0;

	port_flow_control_select i_port_flow_control_select (.*);

	always #5 ref_clk = ~ref_clk;

	// hang guard, generous against about a hundred cycles of traffic
	always @(posedge ref_clk) begin
		cycle_count++;
		if (cycle_count == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	// master holds each channel until its own ready, bready until bvalid
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_awready && s_axi_awvalid)
				s_axi_awvalid <= 0;
			if (s_axi_wready && s_axi_wvalid)
				s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				chk(32'(s_axi_bresp), 32'(er));
				s_axi_bready <= 0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_arready && s_axi_arvalid)
				s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				chk(s_axi_rdata, e);
				chk(32'(s_axi_rresp), 32'(er));
				s_axi_rready <= 0;
				break;
			end
		end
	endtask

	// controls toward the mac as {backpressure, pause rx, pause tx}
	task automatic outs(input logic [2:0] e);
		chk({29'h0, backpressure_active, pause_rx_active, pause_tx_active}, {29'h0, e});
	endtask

	task automatic ld(input logic b, input logic p, input logic m);
		@(posedge ref_clk);
		loader_strap_write <= 1;
		loader_backpressure <= b;
		loader_pause <= p;
		loader_manual <= m;
		@(posedge ref_clk);
		loader_strap_write <= 0;
	endtask

	task automatic do_reset();
		reset <= 1;
		repeat (5) @(posedge ref_clk);
		reset <= 0;
		@(posedge ref_clk);
		chk(32'(config_ready), 32'h0);
		while (config_ready !== 1'b1) @(posedge ref_clk);
	endtask

	initial begin
		do_reset();
		rd(FLOW_CTRL_OFFSET, 32'h0000004E, RESP_OKAY);
		outs(3'h1);
		wr(FLOW_CTRL_OFFSET, 32'hFFFFFF81, 4'hF, RESP_OKAY);
		rd(FLOW_CTRL_OFFSET, 32'h00000001, RESP_OKAY);
		outs(3'h0);
		wr(FLOW_CTRL_OFFSET, 32'h00000007, 4'hF, RESP_OKAY);
		rd(FLOW_CTRL_OFFSET, 32'h0000001F, RESP_OKAY);
		outs(3'h3);
		// negotiation off: the field bits rule even with manual clear
		an_enable <= 0;
		wr(FLOW_CTRL_OFFSET, 32'h00000004, 4'hF, RESP_OKAY);
		rd(FLOW_CTRL_OFFSET, 32'h00000014, RESP_OKAY);
		outs(3'h2);
		link_half_duplex <= 1;
		wr(FLOW_CTRL_OFFSET, 32'h00000047, 4'hF, RESP_OKAY);
		rd(FLOW_CTRL_OFFSET, 32'h00000067, RESP_OKAY);
		outs(3'h4);
		// low byte strobe off means no change
		wr(FLOW_CTRL_OFFSET, 32'h00000000, 4'h0, RESP_OKAY);
		rd(FLOW_CTRL_OFFSET, 32'h00000067, RESP_OKAY);
		wr(12'h1A4, 32'h00000000, 4'hF, RESP_SLVERR);
		rd(12'h1A4, 32'h00000000, RESP_SLVERR);
		rd(FLOW_CTRL_OFFSET, 32'h00000067, RESP_OKAY);
		ld(1'b0, 1'b0, 1'b1);
		rd(FLOW_CTRL_OFFSET, 32'h00000021, RESP_OKAY);
		link_half_duplex <= 0;
		// every fixed interface mode pins manual select high
		for (int m = 1; m < 4; m++) begin
			port_if_mode <= port_mode_e'(m);
			wr(FLOW_CTRL_OFFSET, 32'h00000000, 4'hF, RESP_OKAY);
			rd(FLOW_CTRL_OFFSET, 32'h00000001, RESP_OKAY);
		end
		ld(1'b0, 1'b1, 1'b0);
		rd(FLOW_CTRL_OFFSET, 32'h0000001F, RESP_OKAY);
		outs(3'h3);
		// reset in a fixed mode with all straps low
		backpressure_default_strap <= 0;
		pause_default_strap <= 0;
		do_reset();
		rd(FLOW_CTRL_OFFSET, 32'h00000001, RESP_OKAY);
		print_verdict();
	end
endmodule // port_flow_control_select_tb
